// file: design/atm_pkg.sv
package atm_pkg;
	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFS_CTRL      = 8'h00; // run, source select
	localparam logic [7:0] OFS_COUNT     = 8'h04; // aux_count_pair
	localparam logic [7:0] OFS_FLAGS     = 8'h08; // periph_irq_flags_second
	localparam logic [7:0] OFS_ENABLES   = 8'h0c; // periph_irq_enables_second
	localparam logic [7:0] OFS_COMPARE   = 8'h10; // compare_value_pair
	localparam logic [7:0] OFS_MODE      = 8'h14; // compare_mode_field
	localparam logic [7:0] OFS_COMPANION = 8'h18; // companion_timer_control
	// field positions
	localparam int BIT_RUN     = 0;
	localparam int BIT_SRCSEL  = 1;
	localparam int BIT_OVF     = 1;
	localparam int BIT_OSCEN   = 3;
	localparam int CNT_W       = 16;
	localparam int MODE_W      = 4;
	localparam logic [MODE_W-1:0] MODE_SPECIAL_TRIG = 4'hb;
	localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_ONES = 16'hffff;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one axi4-lite request side from the master
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} atm_wreq_t;

	// state of the write channel handshake
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} atm_wstate_t;
endpackage

// file: design/atm_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser for a pin level; a change counts once the
// second and third stages agree, the first stage feeds only the second
module atm_sync (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic rawPin,
	output logic      level,
	output logic      rise
);
	logic stage1;
	logic stage2;
	logic stage3;
	logic next_level;
	logic next_rise;

	// agreement filter on the two later stages; rise marks a new high level
	always_comb begin
		next_level = level;
		if (stage2 == stage3) begin
			next_level = stage3;
		end
		next_rise = next_level & ~level;
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
			level  <= 1'b0;
			rise   <= 1'b0;
		end else begin
			stage1 <= rawPin;
			stage2 <= stage1;
			stage3 <= stage2;
			level  <= next_level;
			rise   <= next_rise;
		end
	end
endmodule

// file: design/atm_timer.sv
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - count 0000h up to FFFFh, wrap to zero
// - overflow sets and holds the overflow flag
// - request forwarded only while enable bit set
// - low-power oscillator may clock the counter
// - oscillator runs only while its enable set
// - special trigger mode 1011 clears the counter
// - trigger clear never sets the overflow flag
// - software count write beats trigger clear
// - compare value pair sets period in trigger mode
module atm_timer (
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  lowPowerOscPin,
	output logic                       lowPowerOscRun,
	output logic                       auxOverflowIrq
);
	import atm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order
	logic              awHeld;
	logic              wHeld;
	atm_wreq_t         wreq;
	atm_wstate_t       wState;
	logic              next_awHeld;
	logic              next_wHeld;
	atm_wreq_t         next_wreq;
	atm_wstate_t       next_wState;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              doWrite;
	// a write lands in the cycle both halves are held
	assign doWrite = (wState == WR_IDLE) && awHeld && wHeld;
	function automatic logic known(input logic [7:0] a);
		known = (a == OFS_CTRL) || (a == OFS_COUNT) || (a == OFS_FLAGS) ||
			(a == OFS_ENABLES) || (a == OFS_COMPARE) || (a == OFS_MODE) ||
			(a == OFS_COMPANION);
	endfunction
	always_comb begin
		next_awHeld = awHeld;
		next_wHeld  = wHeld;
		next_wreq   = wreq;
		next_wState = wState;
		next_bvalid = s_axi_bvalid;
		next_bresp  = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld  = 1'b1;
			next_wreq.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld   = 1'b1;
			next_wreq.data = s_axi_wdata;
			next_wreq.strb = s_axi_wstrb;
		end
		if (doWrite) begin
			next_wState = WR_RESP;
			next_bvalid = 1'b1;
			next_bresp  = known(wreq.addr) ? RESP_OKAY : RESP_SLVERR;
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
		end else if (wState == WR_RESP && s_axi_bready) begin
			next_wState = WR_IDLE;
			next_bvalid = 1'b0;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			awHeld        <= 1'b0;
			wHeld         <= 1'b0;
			wreq          <= '0;
			wState        <= WR_IDLE;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			awHeld        <= next_awHeld;
			wHeld         <= next_wHeld;
			wreq          <= next_wreq;
			wState        <= next_wState;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			// ready one cycle, only while that half is not yet held
			s_axi_awready <= ~next_awHeld & ~s_axi_awready &
				(next_wState == WR_IDLE) & s_axi_awvalid;
			s_axi_wready  <= ~next_wHeld & ~s_axi_wready &
				(next_wState == WR_IDLE) & s_axi_wvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// software-visible state
	logic              runEn;
	logic              srcSel;
	logic              oscEn;
	logic [CNT_W-1:0]  count;
	logic              ovfFlag;
	logic              ovfEnable;
	logic [CNT_W-1:0]  comparePair;
	logic [MODE_W-1:0] compareMode;
	logic              next_runEn;
	logic              next_srcSel;
	logic              next_oscEn;
	logic [CNT_W-1:0]  next_count;
	logic              next_ovfFlag;
	logic              next_ovfEnable;
	logic [CNT_W-1:0]  next_comparePair;
	logic [MODE_W-1:0] next_compareMode;
	logic              oscRise;
	logic              tick;
	logic              wrap;
	logic              trigFire;
	// pin from the low-power oscillator, brought into core_clk; only its
	// rising edge matters, so the filtered level is left unused
	atm_sync u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.rawPin   (lowPowerOscPin),
		.level    (),
		.rise     (oscRise)
	);
	// source choice: core clock or gated oscillator edge
	assign tick = runEn & (srcSel ? (oscRise & oscEn) : 1'b1);
	assign wrap = tick && (count == CNT_ONES);
	// trigger fires on a match, which makes the compare pair the last count before zero
	assign trigFire = (compareMode == MODE_SPECIAL_TRIG) && tick &&
		(count == comparePair);
	function automatic logic hit(input logic [7:0] a);
		hit = doWrite && (wreq.addr == a) && wreq.strb[0];
	endfunction
	always_comb begin
		next_runEn       = runEn;
		next_srcSel      = srcSel;
		next_oscEn       = oscEn;
		next_count       = count;
		next_ovfFlag     = ovfFlag;
		next_ovfEnable   = ovfEnable;
		next_comparePair = comparePair;
		next_compareMode = compareMode;
		if (tick) begin
			next_count = count + 16'h0001; // wraps to zero
		end
		if (trigFire) begin
			next_count = CNT_ZERO;
		end
		if (doWrite && wreq.addr == OFS_COUNT) begin
			// write wins over a coincident trigger clear
			if (wreq.strb[0]) next_count[7:0] = wreq.data[7:0];
			if (wreq.strb[1]) next_count[15:8] = wreq.data[15:8];
		end
		if (hit(OFS_CTRL)) begin
			next_runEn  = wreq.data[BIT_RUN];
			next_srcSel = wreq.data[BIT_SRCSEL];
		end
		if (hit(OFS_COMPANION)) next_oscEn = wreq.data[BIT_OSCEN];
		if (hit(OFS_ENABLES)) next_ovfEnable = wreq.data[BIT_OVF];
		if (hit(OFS_MODE)) next_compareMode = wreq.data[MODE_W-1:0];
		if (doWrite && wreq.addr == OFS_COMPARE) begin
			if (wreq.strb[0]) next_comparePair[7:0] = wreq.data[7:0];
			if (wreq.strb[1]) next_comparePair[15:8] = wreq.data[15:8];
		end
		// only a zero write clears; a real wrap wins over it
		if (hit(OFS_FLAGS) && !wreq.data[BIT_OVF]) next_ovfFlag = 1'b0;
		// a trigger clear is not a wrap, so it leaves the flag alone
		if (wrap && !trigFire) next_ovfFlag = 1'b1;
	end
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			runEn          <= 1'b0;
			srcSel         <= 1'b0;
			oscEn          <= 1'b0;
			count          <= CNT_ZERO;
			ovfFlag        <= 1'b0;
			ovfEnable      <= 1'b0;
			comparePair    <= CNT_ZERO;
			compareMode    <= '0;
			lowPowerOscRun <= 1'b0;
			auxOverflowIrq <= 1'b0;
		end else begin
			runEn          <= next_runEn;
			srcSel         <= next_srcSel;
			oscEn          <= next_oscEn;
			count          <= next_count;
			ovfFlag        <= next_ovfFlag;
			ovfEnable      <= next_ovfEnable;
			comparePair    <= next_comparePair;
			compareMode    <= next_compareMode;
			lowPowerOscRun <= next_oscEn;
			auxOverflowIrq <= next_ovfFlag & next_ovfEnable;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channel: one cycle to arready, data the next
	logic [31:0] rdWord;
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	// same address decode as the write side, so both answer alike
	always_comb begin
		rdWord  = 32'h0000_0000;
		case (s_axi_araddr)
			OFS_CTRL:      rdWord = {30'h0, srcSel, runEn};
			OFS_COUNT:     rdWord = {16'h0000, count};
			OFS_FLAGS:     rdWord = {30'h0, ovfFlag, 1'b0};
			OFS_ENABLES:   rdWord = {30'h0, ovfEnable, 1'b0};
			OFS_COMPARE:   rdWord = {16'h0000, comparePair};
			OFS_MODE:      rdWord = {28'h0, compareMode};
			OFS_COMPANION: rdWord = {28'h0, oscEn, 3'h0};
			default:       rdWord = 32'h0000_0000;
		endcase
		next_arready = 1'b0;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rdata  = rdWord;
			next_rresp  = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
			next_arready = 1'b1;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_count_wraps: assert property (@(posedge core_clk) disable iff (!nrst)
		(wrap && !(doWrite && wreq.addr == OFS_COUNT)) |=> count == CNT_ZERO)
		else $error("counter did not wrap to zero");
	a_flag_sets: assert property (@(posedge core_clk) disable iff (!nrst)
		(wrap && !trigFire) |=> ovfFlag)
		else $error("overflow did not set flag");
	a_irq_masked: assert property (@(posedge core_clk) disable iff (!nrst)
		auxOverflowIrq |-> $past(ovfEnable) || ovfEnable)
		else $error("request raised while masked");
	a_irq_follows: assert property (@(posedge core_clk) disable iff (!nrst)
		(ovfFlag && ovfEnable) |-> auxOverflowIrq)
		else $error("request missing with flag and enable");
	a_osc_gate: assert property (@(posedge core_clk) disable iff (!nrst)
		(srcSel && !oscEn && !(doWrite && wreq.addr == OFS_COUNT))
		|=> count == $past(count) || count == CNT_ZERO)
		else $error("counter moved with oscillator off");
	a_osc_run: assert property (@(posedge core_clk) disable iff (!nrst)
		lowPowerOscRun == oscEn)
		else $error("oscillator run differs from enable");
	a_trig_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		(trigFire && !(doWrite && wreq.addr == OFS_COUNT))
		|=> count == CNT_ZERO)
		else $error("trigger did not clear counter");
	a_trig_noflag: assert property (@(posedge core_clk) disable iff (!nrst)
		(trigFire && !ovfFlag && !wrap) |=> !ovfFlag)
		else $error("trigger set the flag");
	a_write_wins: assert property (@(posedge core_clk) disable iff (!nrst)
		(trigFire && doWrite && wreq.addr == OFS_COUNT &&
		wreq.strb[1:0] == 2'h3) |=> count == $past(wreq.data[15:0]))
		else $error("trigger beat the software write");
	a_flag_holds: assert property (@(posedge core_clk) disable iff (!nrst)
		(ovfFlag && !hit(OFS_FLAGS)) |=> ovfFlag)
		else $error("flag dropped without a clear");
endmodule

// file: tb/atm_timer_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	errTotal++; $display("Error %0t: got %h expected %h", $time, got, exp); \
	end end
module atm_timer_bench;
	import atm_pkg::*;
	logic        core_clk = 1'b0;
	logic        nrst, lowPowerOscPin, lowPowerOscRun, auxOverflowIrq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [15:0] cmp, start;
	int          errTotal, comparisons, cycles, n;

	////////////////////////////////////////////////////////////////////////
	// clock, and a cycle ceiling so a stuck handshake cannot hang the run
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errTotal++;
			$display("Error %0t: timeout", $time);
			complete_run();
		end
	end

	atm_timer DUT (.core_clk(core_clk), .nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .lowPowerOscPin(lowPowerOscPin),
		.lowPowerOscRun(lowPowerOscRun), .auxOverflowIrq(auxOverflowIrq));

	////////////////////////////////////////////////////////////////////////
	// bus master; entered just after an edge, returns at the answer edge
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 0;
		w = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
	endtask

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		resp = s_axi_rresp;
	endtask

	// slow pin edges: the synchroniser needs a few cycles per level
	task automatic pulses(input int k);
		repeat (k) begin
			lowPowerOscPin <= 1'b1;
			repeat (4) @(posedge core_clk);
			lowPowerOscPin <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
		repeat (8) @(posedge core_clk);
	endtask

	// counter model: plain increment, or back to zero on a compare match
	function automatic logic [31:0] model(logic [15:0] v, int k,
		logic [15:0] c, bit trig);
		for (int i = 0; i < k; i++)
			v = (trig && v == c) ? 16'h0000 : v + 16'h0001;
		return {16'h0000, v};
	endfunction

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence; ready inputs stay high, which the master may do
	initial begin
		{nrst, lowPowerOscPin, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = 17'h00000;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hf;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		void'($urandom(90258));
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 7; i++) begin
			bus_read(8'(i * 4), rd);
			`CHK(rd, 32'h00000000)
		end
		`CHK({lowPowerOscRun, auxOverflowIrq}, 2'b00)
		bus_read(8'h40, rd);
		`CHK({resp, rd}, {RESP_SLVERR, 32'h00000000})
		bus_write(8'h40, $urandom);
		`CHK(resp, RESP_SLVERR)
		$display("test reset done");
		// oscillator enable follows its control bit
		bus_write(OFS_COMPANION, 32'h00000008);
		repeat (2) @(posedge core_clk);
		`CHK(lowPowerOscRun, 1'b1)
		bus_write(OFS_COMPANION, 32'h00000000);
		repeat (2) @(posedge core_clk);
		`CHK(lowPowerOscRun, 1'b0)
		// pin edges count only while the oscillator runs
		bus_write(OFS_CTRL, 32'h00000003);
		bus_write(OFS_COUNT, 32'h00000000);
		pulses(3);
		bus_read(OFS_COUNT, rd);
		`CHK(rd, 32'h00000000)
		bus_write(OFS_COMPANION, 32'h00000008);
		n = $urandom_range(3, 12);
		pulses(n);
		bus_read(OFS_COUNT, rd);
		`CHK(rd, model(16'h0000, n, 16'h0000, 0))
		$display("test oscillator done");
		// wrap at all-ones sets the flag; writing one leaves it
		start = 16'hfffe;
		bus_write(OFS_COUNT, {16'h0000, start});
		pulses(3);
		bus_read(OFS_COUNT, rd);
		`CHK(rd, model(start, 3, 16'h0000, 0))
		bus_write(OFS_FLAGS, 32'h00000002);
		bus_read(OFS_FLAGS, rd);
		`CHK(rd[BIT_OVF], 1'b1)
		repeat (2) @(posedge core_clk);
		`CHK(auxOverflowIrq, 1'b0)
		bus_write(OFS_ENABLES, 32'h00000002);
		repeat (2) @(posedge core_clk);
		`CHK(auxOverflowIrq, 1'b1)
		bus_write(OFS_ENABLES, 32'h00000000);
		repeat (2) @(posedge core_clk);
		`CHK(auxOverflowIrq, 1'b0)
		bus_write(OFS_ENABLES, 32'h00000002);
		bus_write(OFS_FLAGS, 32'h00000000);
		repeat (2) @(posedge core_clk);
		`CHK(auxOverflowIrq, 1'b0)
		$display("test overflow done");
		// trigger mode: compare value is the last count before zero
		cmp = 16'($urandom_range(2, 9));
		bus_write(OFS_MODE, {28'h0000000, MODE_SPECIAL_TRIG});
		bus_write(OFS_COMPARE, {16'h0000, cmp});
		bus_write(OFS_COUNT, 32'h00000000);
		pulses(int'(cmp) + 1);
		bus_read(OFS_COUNT, rd);
		`CHK(rd, model(16'h0000, int'(cmp) + 1, cmp, 1))
		pulses(2);
		bus_read(OFS_COUNT, rd);
		`CHK(rd, model(16'h0000, int'(cmp) + 3, cmp, 1))
		bus_read(OFS_FLAGS, rd);
		`CHK(rd[BIT_OVF], 1'b0)
		`CHK(auxOverflowIrq, 1'b0)
		bus_write(OFS_MODE, 32'h00000000);
		bus_write(OFS_COUNT, {16'h0000, cmp});
		pulses(2);
		bus_read(OFS_COUNT, rd);
		`CHK(rd, model(cmp, 2, cmp, 0))
		$display("test trigger done");
		// core clock source: about one count per cycle while running
		bus_write(OFS_COUNT, 32'h00000000);
		bus_write(OFS_CTRL, 32'h00000001);
		repeat (20) @(posedge core_clk);
		bus_write(OFS_CTRL, 32'h00000000);
		bus_read(OFS_COUNT, rd);
		`CHK(rd >= 32'h14 && rd <= 32'h1e, 1'b1)
		$display("test core clock done");
		// compare zero makes the trigger fire every cycle; a count write
		// landing in one of those cycles must still take hold
		bus_write(OFS_MODE, {28'h0000000, MODE_SPECIAL_TRIG});
		bus_write(OFS_COMPARE, 32'h00000000);
		bus_write(OFS_COUNT, 32'h00000000);
		bus_write(OFS_CTRL, 32'h00000001);
		start = 16'($urandom_range(16'h1000, 16'h8000));
		bus_write(OFS_COUNT, {16'h0000, start});
		bus_write(OFS_CTRL, 32'h00000000);
		bus_read(OFS_COUNT, rd);
		`CHK(rd - {16'h0000, start} <= 32'h10, 1'b1)
		bus_read(OFS_FLAGS, rd);
		`CHK(rd[BIT_OVF], 1'b0)
		$display("test write priority done");
		// reset in mid-run brings the registers back to zero
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		bus_read(OFS_COUNT, rd);
		`CHK(rd, 32'h00000000)
		bus_read(OFS_MODE, rd);
		`CHK(rd, 32'h00000000)
		$display("test mid-run reset done");
		complete_run();
	end
endmodule
